// ==== logic/smbt_pkg.sv ====
/*
 * constants, states and field layout shared by the bus target and its register store.
 * assumes a single 20 MHz clock that samples the bus wires and strap pins.
 */
// Contract
// - enable strap high at power-up: answer to fixed address 0101110
// - enable strap low: address 0101100 or 0101101 from select strap
// - straps sampled at power-up; address frozen at 8th rising clock of first match
// - start is data falling with clock high; then shift 7 address bits MSB first, direction
// - on match pull data low in ack slot; on mismatch stay idle
// - direction 0 is master write, 1 is master read
// - nine clocks per byte; device acks address and written bytes
// - data changes only with clock low; rising data with clock high is stop
// - writes carry one or two bytes; reads return exactly one byte
// - first written byte always loads the register pointer
// - second written byte is stored at the register the pointer selects
// - read returns register at pointer without a pointer write
// - repeated start accepted as a fresh start with a new address byte
// - read after repeated start returns the newly selected register
package smbt_pkg;

	// -------------------------------------------------------------------
	// bus addresses
	// -------------------------------------------------------------------
	localparam logic [6:0] SMBT_ADDR_FIXED    = 7'h2e;
	localparam logic [6:0] SMBT_ADDR_SEL_BASE = 7'h2c;

	// -------------------------------------------------------------------
	// sizes and counts
	// -------------------------------------------------------------------
	localparam int         SMBT_DATA_W      = 8;
	localparam int         SMBT_PTR_W       = 8;
	localparam int         SMBT_DEPTH       = 256;
	localparam logic [3:0] SMBT_CNT_BYTE    = 4'h8;
	localparam logic [3:0] SMBT_CNT_ACK     = 4'h9;
	localparam logic [1:0] SMBT_IDX_PTR     = 2'h0;
	localparam logic [1:0] SMBT_IDX_DATA    = 2'h1;
	localparam logic [7:0] SMBT_PTR_RESET   = 8'h00;
	localparam logic [7:0] SMBT_DATA_RESET  = 8'h00;

	// -------------------------------------------------------------------
	// protocol engine states
	// -------------------------------------------------------------------
	typedef enum logic [2:0] {
		SMBT_IDLE  = 3'b000,
		SMBT_ADDR  = 3'b001,
		SMBT_AACK  = 3'b010,
		SMBT_WDATA = 3'b011,
		SMBT_WACK  = 3'b100,
		SMBT_RDATA = 3'b101,
		SMBT_RACK  = 3'b110,
		SMBT_SKIP  = 3'b111
	} smbt_state_t;

endpackage : smbt_pkg

// ==== logic/smbt_regmem.sv ====
/*
 * register store: one write port, one read port with registered read data.
 * assumes the caller holds the read address steady for a cycle before using data.
 */
`timescale 1ns/10ps
module smbt_regmem (
	input  wire logic                        i_clk,
	input  wire logic                        i_we,
	input  wire logic [smbt_pkg::SMBT_PTR_W-1:0]  i_waddr,
	input  wire logic [smbt_pkg::SMBT_DATA_W-1:0] i_wdata,
	input  wire logic [smbt_pkg::SMBT_PTR_W-1:0]  i_raddr,
	output logic      [smbt_pkg::SMBT_DATA_W-1:0] o_rdata
);

	logic [smbt_pkg::SMBT_DATA_W-1:0] mem [smbt_pkg::SMBT_DEPTH];

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// write-through so a read right after a store sees the new byte
	always_ff @(posedge i_clk) begin
		if (i_we && (i_waddr == i_raddr)) begin
			o_rdata <= i_wdata;
		end else begin
			o_rdata <= mem[i_raddr];
		end
	end

endmodule : smbt_regmem

// ==== logic/smbt_target.sv ====
/*
 * bus target: strap address select, start/stop detection, address and data
 * shifting, acknowledge drive, register pointer and register store access.
 * assumes the bus clock is far slower than i_clk (several i_clk per phase)
 * and that the data pin is open drain with an external pull-up.
 */
`timescale 1ns/10ps
module smbt_target (
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic       i_address_strap_enable,
	input  wire logic       i_address_select,
	output logic            o_sda_out,
	output logic            o_sda_oe,
	output logic            o_addr_locked,
	output logic      [6:0] o_dev_addr,
	output logic      [7:0] o_ptr
);

	// -------------------------------------------------------------------
	// reset release and input synchronisers
	// -------------------------------------------------------------------
	logic       rst_s1_q, rst_n_q;
	logic [3:0] pin_s1_q, pin_s2_q;
	logic       scl_prev_q, sda_prev_q;
	logic       scl_s, sda_s;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pin_s1_q <= 4'hf;
			pin_s2_q <= 4'hf;
		end else begin
			pin_s1_q <= {i_scl, i_sda, i_address_strap_enable, i_address_select};
			pin_s2_q <= pin_s1_q;
		end
	end

	assign scl_s = pin_s2_q[3];
	assign sda_s = pin_s2_q[2];

	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	logic scl_rise, scl_fall, start_ev, stop_ev;
	assign scl_rise = scl_s && !scl_prev_q;
	assign scl_fall = !scl_s && scl_prev_q;
	assign start_ev = scl_s && scl_prev_q && sda_prev_q && !sda_s;
	assign stop_ev  = scl_s && scl_prev_q && !sda_prev_q && sda_s;

	// -------------------------------------------------------------------
	// strap sampling and address lock
	// -------------------------------------------------------------------
	function automatic logic [6:0] strap_addr(input logic en, input logic sel);
		strap_addr = en ? smbt_pkg::SMBT_ADDR_FIXED
		                : (smbt_pkg::SMBT_ADDR_SEL_BASE | {6'h00, sel});
	endfunction : strap_addr

	logic       strap_taken_q, locked_q;
	logic [6:0] dev_addr_q;
	logic [7:0] shift_q;
	logic [3:0] cnt_q;
	logic       addr_hit;

	// the lock looks before the direction bit lands; the ack decision looks after it,
	// when the address has moved up into the top seven bits
	logic byte_hit;
	assign addr_hit = (shift_q[6:0] == dev_addr_q);
	assign byte_hit = (shift_q[7:1] == dev_addr_q);

	// straps are caught once, on the first cycle with the synchronisers filled
	logic [1:0] warm_q;
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			warm_q        <= 2'h0;
			strap_taken_q <= 1'b0;
			dev_addr_q    <= smbt_pkg::SMBT_ADDR_FIXED;
		end else if (!warm_q[1]) begin
			warm_q <= {warm_q[0], 1'b1};
		end else if (!strap_taken_q && !locked_q) begin
			strap_taken_q <= 1'b1;
			dev_addr_q    <= strap_addr(pin_s2_q[1], pin_s2_q[0]);
		end
	end

	logic state_addr;
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			locked_q <= 1'b0;
		end else if (state_addr && scl_rise && cnt_q == 4'h7 && addr_hit && strap_taken_q) begin
			locked_q <= 1'b1;
		end
	end

	// -------------------------------------------------------------------
	// protocol engine
	// -------------------------------------------------------------------
	smbt_pkg::smbt_state_t state_q;
	logic       rw_q, oe_q, ptr_wr, mem_we, tx_load;
	logic [1:0] idx_q;
	logic [7:0] ptr_q, tx_q, rdata;

	assign state_addr = (state_q == smbt_pkg::SMBT_ADDR);
	assign ptr_wr  = (state_q == smbt_pkg::SMBT_WDATA) && scl_fall && cnt_q == smbt_pkg::SMBT_CNT_BYTE
	                 && idx_q == smbt_pkg::SMBT_IDX_PTR;
	assign mem_we  = (state_q == smbt_pkg::SMBT_WDATA) && scl_fall && cnt_q == smbt_pkg::SMBT_CNT_BYTE
	                 && idx_q == smbt_pkg::SMBT_IDX_DATA;
	assign tx_load = (state_q == smbt_pkg::SMBT_AACK) && scl_fall && cnt_q == smbt_pkg::SMBT_CNT_ACK
	                 && rw_q;

	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cnt_q   <= 4'h0;
			shift_q <= 8'h00;
		end else if (start_ev || stop_ev) begin
			cnt_q <= 4'h0;
		end else if (scl_rise) begin
			shift_q <= {shift_q[6:0], sda_s};
			if (cnt_q != smbt_pkg::SMBT_CNT_ACK) begin
				cnt_q <= cnt_q + 4'h1;
			end
		end else if (scl_fall && cnt_q == smbt_pkg::SMBT_CNT_ACK) begin
			cnt_q <= 4'h0;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= smbt_pkg::SMBT_IDLE;
			rw_q    <= 1'b0;
			idx_q   <= 2'h0;
		end else if (start_ev) begin
			state_q <= smbt_pkg::SMBT_ADDR;
		end else if (stop_ev) begin
			state_q <= smbt_pkg::SMBT_IDLE;
		end else begin
			unique case (state_q)
				smbt_pkg::SMBT_IDLE, smbt_pkg::SMBT_SKIP: begin
					state_q <= state_q;
				end
				smbt_pkg::SMBT_ADDR: begin
					if (scl_rise && cnt_q == 4'h7) begin
						rw_q <= sda_s;
					end
					if (scl_fall && cnt_q == smbt_pkg::SMBT_CNT_BYTE) begin
						state_q <= (byte_hit && strap_taken_q) ? smbt_pkg::SMBT_AACK
						                                       : smbt_pkg::SMBT_SKIP;
					end
				end
				smbt_pkg::SMBT_AACK: begin
					if (scl_fall && cnt_q == smbt_pkg::SMBT_CNT_ACK) begin
						state_q <= rw_q ? smbt_pkg::SMBT_RDATA : smbt_pkg::SMBT_WDATA;
						idx_q   <= smbt_pkg::SMBT_IDX_PTR;
					end
				end
				smbt_pkg::SMBT_WDATA: begin
					if (scl_fall && cnt_q == smbt_pkg::SMBT_CNT_BYTE) begin
						// a third byte is not acknowledged
						state_q <= (idx_q == 2'h2) ? smbt_pkg::SMBT_SKIP
						                           : smbt_pkg::SMBT_WACK;
					end
				end
				smbt_pkg::SMBT_WACK: begin
					if (scl_fall && cnt_q == smbt_pkg::SMBT_CNT_ACK) begin
						state_q <= smbt_pkg::SMBT_WDATA;
						idx_q   <= idx_q + 2'h1;
					end
				end
				smbt_pkg::SMBT_RDATA: begin
					if (scl_fall && cnt_q == smbt_pkg::SMBT_CNT_BYTE) begin
						state_q <= smbt_pkg::SMBT_RACK;
					end
				end
				smbt_pkg::SMBT_RACK: begin
					// only one byte per read, whatever the master answers
					if (scl_fall && cnt_q == smbt_pkg::SMBT_CNT_ACK) begin
						state_q <= smbt_pkg::SMBT_SKIP;
					end
				end
			endcase
		end
	end

	// -------------------------------------------------------------------
	// pointer, store and transmit shifter
	// -------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ptr_q <= smbt_pkg::SMBT_PTR_RESET;
		end else if (ptr_wr) begin
			ptr_q <= shift_q;
		end
	end

	smbt_regmem u_mem (
		.i_clk   (i_clk),
		.i_we    (mem_we),
		.i_waddr (ptr_q),
		.i_wdata (shift_q),
		.i_raddr (ptr_q),
		.o_rdata (rdata)
	);

	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tx_q <= smbt_pkg::SMBT_DATA_RESET;
		end else if (tx_load) begin
			tx_q <= rdata;
		end else if (state_q == smbt_pkg::SMBT_RDATA && scl_fall) begin
			tx_q <= {tx_q[6:0], 1'b1};
		end
	end

	// drive changes on a falling clock so data is stable while high, and is cleared on start or stop
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			oe_q <= 1'b0;
		end else if (start_ev || stop_ev) begin
			oe_q <= 1'b0;
		end else if (scl_fall) begin
			unique case (state_q)
				smbt_pkg::SMBT_ADDR:  oe_q <= (cnt_q == smbt_pkg::SMBT_CNT_BYTE) && byte_hit
				                              && strap_taken_q;
				smbt_pkg::SMBT_WDATA: oe_q <= (cnt_q == smbt_pkg::SMBT_CNT_BYTE)
				                              && (idx_q != 2'h2);
				smbt_pkg::SMBT_AACK:  oe_q <= rw_q && (cnt_q == smbt_pkg::SMBT_CNT_ACK)
				                              && !rdata[7];
				smbt_pkg::SMBT_RDATA: oe_q <= (cnt_q != smbt_pkg::SMBT_CNT_BYTE) && !tx_q[6];
				smbt_pkg::SMBT_WACK:  oe_q <= (cnt_q == smbt_pkg::SMBT_CNT_ACK) ? 1'b0 : oe_q;
				default:              oe_q <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_sda_out     <= 1'b0;
			o_sda_oe      <= 1'b0;
			o_addr_locked <= 1'b0;
			o_dev_addr    <= smbt_pkg::SMBT_ADDR_FIXED;
			o_ptr         <= smbt_pkg::SMBT_PTR_RESET;
		end else begin
			o_sda_out     <= 1'b0;
			o_sda_oe      <= oe_q;
			o_addr_locked <= locked_q;
			o_dev_addr    <= dev_addr_q;
			o_ptr         <= ptr_q;
		end
	end

	// -------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_n_q);

	property p_fixed_addr;
		strap_taken_q && $past(pin_s2_q[1]) && $rose(strap_taken_q) |-> dev_addr_q == 7'h2e;
	endproperty
	a_fixed_addr: assert property (p_fixed_addr) else $error("fixed address wrong");

	property p_sel_addr;
		$rose(strap_taken_q) && !$past(pin_s2_q[1]) |-> dev_addr_q == {6'h16, $past(pin_s2_q[0])};
	endproperty
	a_sel_addr: assert property (p_sel_addr) else $error("select address wrong");

	property p_addr_frozen;
		strap_taken_q |=> $stable(dev_addr_q);
	endproperty
	a_addr_frozen: assert property (p_addr_frozen) else $error("address changed");

	property p_start_to_addr;
		start_ev |=> state_addr && cnt_q == 4'h0 && !oe_q;
	endproperty
	a_start_to_addr: assert property (p_start_to_addr) else $error("start not taken");

	property p_miss_quiet;
		state_q == smbt_pkg::SMBT_SKIP |-> !oe_q;
	endproperty
	a_miss_quiet: assert property (p_miss_quiet) else $error("drives on miss");

	property p_addr_ack;
		state_q == smbt_pkg::SMBT_AACK && cnt_q == 4'h8 && !scl_rise |-> oe_q;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("no address ack");

	property p_stop_idle;
		stop_ev |=> state_q == smbt_pkg::SMBT_IDLE ##1 !o_sda_oe;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");

	property p_ptr_load;
		ptr_wr |=> ptr_q == $past(shift_q) ##1 o_ptr == $past(shift_q, 2);
	endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

	property p_store_second;
		mem_we |-> idx_q == 2'h1 && !ptr_wr ##1 rdata == $past(shift_q);
	endproperty
	a_store_second: assert property (p_store_second) else $error("store on wrong byte");

	property p_read_data;
		tx_load |=> tx_q == $past(rdata);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read byte wrong");

	property p_ptr_hold;
		!ptr_wr |=> $stable(ptr_q);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");

	c_write_two: cover property (mem_we);
	c_read_one:  cover property (tx_load);
	c_restart:   cover property (state_q == smbt_pkg::SMBT_WACK ##[1:1000] start_ev);
	c_lock:      cover property ($rose(locked_q));

endmodule : smbt_target

// ==== verif/smbt_master_model.sv ====
/*
 * bus master model: drives the clock line and pulls the data line low.
 * assumes the data wire is resolved outside, with a pull-up.
 */
`timescale 1ns/10ps
module smbt_master_model #(
	parameter int T_LO = 5,
	parameter int T_HI = 3
) (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_oe
);
	// clock stands high and data is released outside frames
	initial begin
		o_scl    = 1'b1;
		o_sda_oe = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge i_clk);
	endtask : wt

	// one pulse: data set early in the low phase, sampled late in the high phase;
	// the low phase is the longer one so the target's answer, 4 clocks after
	// the falling edge, still lands while the clock is low
	task automatic bit_io(input logic b, output logic s);
		wt(2);
		o_sda_oe <= ~b;
		wt(T_LO - 2);
		o_scl <= 1'b1;
		wt(T_HI - 1);
		@(negedge i_clk);
		s = i_sda;
		wt(1);
		o_scl <= 1'b0;
	endtask : bit_io

	// also serves as a repeated start after an ack slot
	task automatic start();
		wt(2);
		o_sda_oe <= 1'b0;
		wt(T_LO - 2);
		o_scl <= 1'b1;
		wt(T_HI);
		o_sda_oe <= 1'b1;
		wt(T_HI);
		o_scl <= 1'b0;
	endtask : start

	task automatic stop();
		wt(2);
		o_sda_oe <= 1'b1;
		wt(T_LO - 2);
		o_scl <= 1'b1;
		wt(T_HI);
		o_sda_oe <= 1'b0;
		wt(T_LO);
	endtask : stop

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask : wbyte

	task automatic rbyte(output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		// no-ack ends the read
		bit_io(1'b1, s);
	endtask : rbyte
endmodule : smbt_master_model

// ==== verif/smbt_target_test.sv ====
/*
 * self-checking bench for the bus target, with a master model on the wire.
 * assumes the target's assertions sit in its own files.
 */
`timescale 1ns/10ps
module smbt_target_test;
	logic       clk;
	logic       nrst;
	logic       strap_en;
	logic       strap_sel;
	logic       scl;
	logic       m_oe;
	logic       sda_out;
	logic       sda_oe;
	logic       locked;
	logic [6:0] dev_addr;
	logic [7:0] ptr;
	logic       sda;
	logic [6:0] dev;
	int         err_total;
	int         total_checks;

	// open-drain wire with pull-up
	assign sda = ~(m_oe | (sda_oe & ~sda_out));

	smbt_target DUT (
		.i_clk                  (clk),
		.i_nrst                 (nrst),
		.i_scl                  (scl),
		.i_sda                  (sda),
		.i_address_strap_enable (strap_en),
		.i_address_select       (strap_sel),
		.o_sda_out              (sda_out),
		.o_sda_oe               (sda_oe),
		.o_addr_locked          (locked),
		.o_dev_addr             (dev_addr),
		.o_ptr                  (ptr)
	);

	// 400 ns bus clock: 5 clocks low, 3 high, so the 4 clock answer lands while low
	smbt_master_model #(.T_LO(5), .T_HI(3)) bus (
		.i_clk    (clk),
		.i_sda    (sda),
		.o_scl    (scl),
		.o_sda_oe (m_oe)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic do_reset();
		nrst <= 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (12) @(posedge clk);
	endtask : do_reset

	task automatic send(input logic [7:0] b, input logic exp_ack);
		logic a;
		bus.wbyte(b, a);
		chk(8'(a), 8'(exp_ack), "ack");
	endtask : send

	// receive one byte; without a stop before it this is a repeated start
	task automatic rd(input logic [7:0] exp);
		logic [7:0] d;
		bus.start();
		send({dev, 1'b1}, 1'b1);
		bus.rbyte(d);
		bus.stop();
		chk(d, exp, "read");
	endtask : rd

	task automatic t_straps();
		logic [1:0] cfg [3] = '{2'b00, 2'b01, 2'b10};
		logic [6:0] exp;
		for (int i = 0; i < 3; i++) begin
			exp = smbt_pkg::SMBT_ADDR_SEL_BASE | 7'(cfg[i][0]);
			if (cfg[i][1]) begin
				exp = smbt_pkg::SMBT_ADDR_FIXED;
			end
			strap_en  <= cfg[i][1];
			strap_sel <= cfg[i][0];
			do_reset();
			chk(8'(dev_addr), 8'(exp), "addr");
			bus.start();
			send({exp ^ 7'h10, 1'b0}, 1'b0);
			bus.stop();
			chk(8'(locked), 8'h00, "lock");
			bus.start();
			send({exp, 1'b0}, 1'b1);
			send(8'h40 + 8'(i), 1'b1);
			bus.stop();
			chk(ptr, 8'h40 + 8'(i), "ptr");
			chk(8'(locked), 8'h01, "lock");
			// late strap moves must not disturb the frozen address
			strap_en  <= ~cfg[i][1];
			strap_sel <= ~cfg[i][0];
			repeat (12) @(posedge clk);
			chk(8'(dev_addr), 8'(exp), "addr");
			bus.start();
			send({exp, 1'b0}, 1'b1);
			bus.stop();
		end
		$display("strap test done");
	endtask : t_straps

	task automatic t_write_read();
		bus.start();
		send({dev, 1'b0}, 1'b1);
		send(8'h5a, 1'b1);
		send(8'hc3, 1'b1);
		send(8'hff, 1'b0);
		bus.stop();
		chk(ptr, 8'h5a, "ptr");
		rd(8'hc3);
		rd(8'hc3);
		chk(ptr, 8'h5a, "ptr");
		$display("write read test done");
	endtask : t_write_read

	task automatic t_rep_start();
		bus.start();
		send({dev, 1'b0}, 1'b1);
		send(8'h33, 1'b1);
		send(8'h96, 1'b1);
		bus.stop();
		bus.start();
		send({dev, 1'b0}, 1'b1);
		send(8'h5a, 1'b1);
		rd(8'hc3);
		bus.start();
		send({dev, 1'b0}, 1'b1);
		send(8'h33, 1'b1);
		rd(8'h96);
		chk(ptr, 8'h33, "ptr");
		$display("repeated start test done");
	endtask : t_rep_start

	initial begin
		err_total    = 0;
		total_checks = 0;
		nrst         = 1'b0;
		strap_en     = 1'b1;
		strap_sel    = 1'b0;
		dev          = smbt_pkg::SMBT_ADDR_FIXED;
		do_reset();
		// the last strap case leaves the fixed address frozen
		t_straps();
		t_write_read();
		t_rep_start();
		give_verdict();
	end

	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		$display("CHECK FAILED t=%0t run limit reached", $time);
		give_verdict();
	end
endmodule : smbt_target_test
